// >>> rtl/liuhw_pkg.sv
/*
 * Constants and mode types for the hardware-mode pin decoder.
 * Assumes a 40 MHz pclk.
 */
`default_nettype none
package liuhw_pkg;
    // Clock and reset timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int RST_MIN_NS     = 100;
    // Longer than the minimum low time, so one more cycle than 100/25
    localparam int RST_MIN_CYC    = RST_MIN_NS / CLK_PERIOD_NS + 1;
    localparam int RST_CNT_W      = 3;

    // Register map
    localparam logic [11:0] ADDR_STATUS  = 12'h000;
    localparam logic [11:0] ADDR_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_MUXDATA = 12'h008;
    localparam logic [31:0] CONTROL_RST  = 32'h0000_0000;

    // Status and control field positions
    localparam int ST_EQ     = 0;
    localparam int ST_RPD    = 1;
    localparam int ST_PATT   = 2;
    localparam int ST_JA     = 4;
    localparam int ST_THZ    = 6;
    localparam int ST_IFMODE = 8;
    localparam int ST_RESET  = 10;
    localparam int ST_PULSE  = 12;
    localparam int CTL_SOFT_RESET = 0;

    // Gain ranges in dB and jitter FIFO depths
    localparam int GAIN_SHORT_DB   = 10;
    localparam int GAIN_LONG_T1_DB = 36;
    localparam int GAIN_LONG_E1_DB = 43;
    localparam int JA_FIFO_SHORT   = 64;
    localparam int JA_FIFO_LONG    = 128;

    typedef enum logic [1:0] {
        IF_HARDWARE, IF_SERIAL, IF_MOTOROLA, IF_INTEL
    } liuhw_if_t;

    typedef enum logic [1:0] {
        TXP_NORMAL, TXP_ALL_ONES, TXP_PRBS, TXP_POWERDOWN
    } liuhw_txp_t;

    typedef enum logic [1:0] {
        JA_OFF, JA_RX_BROAD, JA_RX_NARROW, JA_TX_NARROW
    } liuhw_ja_t;
endpackage : liuhw_pkg
`default_nettype wire

// >>> rtl/liuhw_sync.sv
/*
 * Two-flop synchroniser for the static strap pins.
 * Assumes inputs are asynchronous to pclk.
 */
`default_nettype none
module liuhw_sync (
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Pins
    liuhw_sync_if.sync sif
);
    logic [13:0] meta_ff;
    logic [13:0] sync_ff;
    logic [13:0] nxt_meta;
    logic [13:0] nxt_sync;

    always_comb begin
        nxt_meta = sif.raw;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 14'h0000;
            sync_ff <= 14'h0000;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sif.synced = sync_ff;
endmodule : liuhw_sync
`default_nettype wire

// >>> rtl/liuhw_sync_if.sv
/*
 * Carrier between top and the pin synchroniser.
 * Assumes both sit on pclk.
 */
`default_nettype none
interface liuhw_sync_if;
    logic [13:0] raw;
    logic [13:0] synced;
    modport src  (output raw,    input synced);
    modport sync (input  raw,    output synced);
endinterface : liuhw_sync_if
`default_nettype wire

// >>> rtl/liuhw_top.sv
/*
 * Hardware-mode pin decoder of a single-channel line interface unit.
 * Assumes static pins asynchronous to pclk, an APB master on pclk,
 * and a pad ring that resolves the shared bus from its enable.
 */
`default_nettype none
module liuhw_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Configuration pins
    input  wire logic [1:0]  if_mode_select,
    input  wire logic        chip_reset_n,
    input  wire logic        line_gain_range_select,
    input  wire logic        rx_powerdown_pin,
    input  wire logic [1:0]  tx_test_sequence_select,
    input  wire logic [1:0]  jitter_filter_select,
    input  wire logic        tx_driver_float,
    input  wire logic [3:0]  line_template_select,
    // Shared address/data pins
    input  wire logic [7:0]  mux_bus_in,
    output logic      [7:0]  mux_bus_out,
    output logic             mux_bus_oe,
    // Decoded controls
    output logic             core_reset,
    output logic             eq_long_haul,
    output logic             rx_powerdown,
    output logic             tx_powerdown,
    output logic [1:0]       tx_pattern,
    output logic [1:0]       ja_mode,
    output logic             ja_in_tx_path,
    output logic             ja_fifo_deep,
    output logic             ja_narrow_bw,
    output logic             tx_driver_oe
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    liuhw_sync_if sif ();
    logic [13:0] pins;

    assign sif.raw = {line_template_select, chip_reset_n, if_mode_select,
                      tx_driver_float, jitter_filter_select,
                      tx_test_sequence_select, rx_powerdown_pin,
                      line_gain_range_select};

    liuhw_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
    );
    assign pins = sif.synced;

    logic             s_eq;
    logic             s_rpd;
    logic [1:0]       s_patt;
    logic [1:0]       s_ja;
    logic             s_thz;
    logic [1:0]       s_mode;
    logic             s_rstn;
    logic [3:0]       s_puls;
    assign s_eq   = pins[0];
    assign s_rpd  = pins[1];
    assign s_patt = pins[3:2];
    assign s_ja   = pins[5:4];
    assign s_thz  = pins[6];
    assign s_mode = pins[8:7];
    assign s_rstn = pins[9];
    assign s_puls = pins[13:10];

    function automatic logic is_hw(input logic [1:0] m);
        return m == liuhw_pkg::IF_HARDWARE;
    endfunction

    function automatic logic is_mux(input logic [1:0] m);
        return m == liuhw_pkg::IF_MOTOROLA || m == liuhw_pkg::IF_INTEL;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset pin filter
    logic [2:0] rst_cnt_ff;
    logic [2:0] nxt_rst_cnt;
    logic       core_reset_ff;
    logic       nxt_core_reset;
    logic       soft_reset_ff;

    always_comb begin
        nxt_rst_cnt    = rst_cnt_ff;
        nxt_core_reset = core_reset_ff;
        if (s_rstn) begin
            nxt_rst_cnt    = 3'h0;
            nxt_core_reset = 1'b0;
        end else if (rst_cnt_ff < 3'(liuhw_pkg::RST_MIN_CYC)) begin
            nxt_rst_cnt = rst_cnt_ff + 3'h1;
        end else begin
            nxt_core_reset = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_ff    <= 3'h0;
            core_reset_ff <= 1'b1;
        end else begin
            rst_cnt_ff    <= nxt_rst_cnt;
            core_reset_ff <= nxt_core_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded controls, tracking pins live
    logic       eq_ff, rpd_ff, txpd_ff, ja_tx_ff, ja_deep_ff, ja_nb_ff;
    logic       drv_oe_ff, rst_out_ff;
    logic [1:0] patt_ff, ja_ff;
    logic       nxt_eq, nxt_rpd, nxt_txpd, nxt_ja_tx, nxt_ja_deep, nxt_ja_nb;
    logic       nxt_drv_oe, nxt_rst_out;
    logic [1:0] nxt_patt, nxt_ja;

    always_comb begin
        nxt_eq      = 1'b0;
        nxt_rpd     = 1'b0;
        nxt_patt    = liuhw_pkg::TXP_NORMAL;
        nxt_txpd    = 1'b0;
        nxt_ja      = liuhw_pkg::JA_OFF;
        nxt_ja_tx   = 1'b0;
        nxt_ja_deep = 1'b0;
        nxt_ja_nb   = 1'b0;
        nxt_rst_out = core_reset_ff | soft_reset_ff;
        nxt_drv_oe  = ~s_thz;
        if (is_hw(s_mode)) begin
            nxt_eq  = s_eq;
            nxt_rpd = s_rpd;
            case (s_patt)
                liuhw_pkg::TXP_POWERDOWN: begin
                    nxt_patt = liuhw_pkg::TXP_NORMAL;
                    nxt_txpd = 1'b1;
                end
                default: begin
                    nxt_patt = s_patt;
                end
            endcase
            case (s_ja)
                liuhw_pkg::JA_OFF: begin
                    nxt_ja = liuhw_pkg::JA_OFF;
                end
                liuhw_pkg::JA_RX_BROAD: begin
                    nxt_ja = liuhw_pkg::JA_RX_BROAD;
                end
                liuhw_pkg::JA_RX_NARROW: begin
                    nxt_ja      = liuhw_pkg::JA_RX_NARROW;
                    nxt_ja_deep = 1'b1;
                    nxt_ja_nb   = 1'b1;
                end
                default: begin
                    nxt_ja      = liuhw_pkg::JA_TX_NARROW;
                    nxt_ja_tx   = 1'b1;
                    nxt_ja_deep = 1'b1;
                    nxt_ja_nb   = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq_ff      <= 1'b0;
            rpd_ff     <= 1'b0;
            patt_ff    <= 2'h0;
            txpd_ff    <= 1'b0;
            ja_ff      <= 2'h0;
            ja_tx_ff   <= 1'b0;
            ja_deep_ff <= 1'b0;
            ja_nb_ff   <= 1'b0;
            drv_oe_ff  <= 1'b0;
            rst_out_ff <= 1'b1;
        end else begin
            eq_ff      <= nxt_eq;
            rpd_ff     <= nxt_rpd;
            patt_ff    <= nxt_patt;
            txpd_ff    <= nxt_txpd;
            ja_ff      <= nxt_ja;
            ja_tx_ff   <= nxt_ja_tx;
            ja_deep_ff <= nxt_ja_deep;
            ja_nb_ff   <= nxt_ja_nb;
            drv_oe_ff  <= nxt_drv_oe;
            rst_out_ff <= nxt_rst_out;
        end
    end

    drv_on_a: assert property (
        @(posedge pclk) disable iff (!presetn) !s_thz |=> tx_driver_oe)
        else $error("driver not enabled");
    drv_off_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_thz |=> !tx_driver_oe)
        else $error("driver not floated");
    rx_pd_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_hw(s_mode) && s_rpd |=> rx_powerdown)
        else $error("receiver powerdown missing");
    tx_pd_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_hw(s_mode) && s_patt == 2'b11 |=> tx_powerdown)
        else $error("transmitter powerdown missing");
    ja_deep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_hw(s_mode) && s_ja[1] |=> ja_fifo_deep && ja_narrow_bw)
        else $error("jitter fifo depth wrong");
    gain_pin_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_hw(s_mode) |=> eq_long_haul == $past(s_eq))
        else $error("gain range wrong");
    rst_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn) s_rstn |=> !core_reset_ff)
        else $error("reset filter stuck");

    ////////////////////////////////////////////////////////////////////////
    // APB slave and shared bus
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pslverr_ff, nxt_pslverr;
    logic        nxt_soft_reset;
    logic [7:0]  bus_out_ff, nxt_bus_out;
    logic        bus_oe_ff, nxt_bus_oe;
    logic        acc;

    assign acc = psel & penable;

    always_comb begin
        nxt_prdata     = prdata_ff;
        nxt_pslverr    = 1'b0;
        nxt_soft_reset = soft_reset_ff;
        nxt_bus_out    = bus_out_ff;
        nxt_bus_oe     = 1'b0;
        // Read data built in setup so it stands during the access cycle
        if (psel && !penable) begin
            nxt_prdata = 32'h0000_0000;
            case (paddr)
                liuhw_pkg::ADDR_STATUS: begin
                    nxt_prdata[liuhw_pkg::ST_EQ]          = s_eq;
                    nxt_prdata[liuhw_pkg::ST_RPD]         = s_rpd;
                    nxt_prdata[liuhw_pkg::ST_PATT+:2]     = s_patt;
                    nxt_prdata[liuhw_pkg::ST_JA+:2]       = s_ja;
                    nxt_prdata[liuhw_pkg::ST_THZ]         = s_thz;
                    nxt_prdata[liuhw_pkg::ST_IFMODE+:2]   = s_mode;
                    nxt_prdata[liuhw_pkg::ST_RESET]       = core_reset_ff;
                    nxt_prdata[liuhw_pkg::ST_PULSE+:4]    = s_puls;
                end
                liuhw_pkg::ADDR_CONTROL: begin
                    nxt_prdata[liuhw_pkg::CTL_SOFT_RESET] = soft_reset_ff;
                end
                liuhw_pkg::ADDR_MUXDATA: begin
                    nxt_prdata[7:0] = bus_out_ff;
                end
                default: begin
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
        // Writes land at the access edge only
        if (acc) begin
            nxt_pslverr = pslverr_ff;
            if (pwrite && paddr == liuhw_pkg::ADDR_CONTROL) begin
                nxt_soft_reset = pwdata[liuhw_pkg::CTL_SOFT_RESET];
            end
            if (pwrite && paddr == liuhw_pkg::ADDR_MUXDATA) begin
                nxt_bus_out = pwdata[7:0];
            end
        end
        // drive shared bus only in muxed read
        if (is_mux(s_mode) && acc && !pwrite &&
            paddr == liuhw_pkg::ADDR_MUXDATA) begin
            nxt_bus_oe = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff     <= 32'h0000_0000;
            pslverr_ff    <= 1'b0;
            soft_reset_ff <= 1'b0;
            bus_out_ff    <= 8'h00;
            bus_oe_ff     <= 1'b0;
        end else begin
            prdata_ff     <= nxt_prdata;
            pslverr_ff    <= nxt_pslverr;
            soft_reset_ff <= nxt_soft_reset;
            bus_out_ff    <= nxt_bus_out;
            bus_oe_ff     <= nxt_bus_oe;
        end
    end

    mux_oe_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        mux_bus_oe |-> $past(acc && !pwrite))
        else $error("shared bus driven without read");

    // Single cycle answers: pready high throughout, data on the next edge
    assign pready        = 1'b1;
    assign prdata        = prdata_ff;
    assign pslverr       = pslverr_ff;
    assign mux_bus_out   = bus_out_ff;
    assign mux_bus_oe    = bus_oe_ff;
    assign core_reset    = rst_out_ff;
    assign eq_long_haul  = eq_ff;
    assign rx_powerdown  = rpd_ff;
    assign tx_powerdown  = txpd_ff;
    assign tx_pattern    = patt_ff;
    assign ja_mode       = ja_ff;
    assign ja_in_tx_path = ja_tx_ff;
    assign ja_fifo_deep  = ja_deep_ff;
    assign ja_narrow_bw  = ja_nb_ff;
    assign tx_driver_oe  = drv_oe_ff;
endmodule : liuhw_top
`default_nettype wire

// >>> verif/liuhw_strap_model.sv
/*
 * Board strapping and host model for the pin decoder.
 * Assumes the bench supplies pclk and the requested strap values.
 */
`default_nettype none
module liuhw_strap_model (
    // Clock
    input  wire logic        pclk,
    // Requested straps: b1:0 mode,b2 gain,b3 rpd,b5:4 patt,b7:6 ja,b8 float
    input  wire logic [12:0] want,
    // Strap pins
    output logic      [12:0] pins,
    // Shared bus
    input  wire logic [7:0]  bus_out,
    input  wire logic        bus_oe,
    output logic      [7:0]  bus_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last;
    always_ff @(posedge pclk) begin
        pins <= {want[12:8], (want[1:0] == 2'b00) ? want[7:6] : 2'b00,
                 want[5:0]};
    end
    always_ff @(posedge pclk) begin
        last <= bus_in;
    end
    assign bus_in = bus_oe ? bus_out : ~last;
endmodule // liuhw_strap_model
`default_nettype wire

// >>> verif/liuhw_top_tb.sv
/*
 * Self-checking bench for the hardware-mode pin decoder.
 * Assumes liuhw_top and the strap model; pclk at 40 MHz.
 */
`default_nettype none
module liuhw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, chip_reset_n = 1'b1, pready, pslverr, oe_seen;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [12:0] want = 13'h0000, pins;
    logic [7:0]  bus_in, bus_out;
    logic [10:0] dec;
    logic        bus_oe, core_reset, er;
    int          err_count = 0, comparisons = 0, seed = 57502;

    always #12.5 pclk = ~pclk;

    liuhw_strap_model i_liuhw_strap_model (.pclk(pclk), .want(want),
        .pins(pins), .bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_in));
    liuhw_top i_liuhw_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .if_mode_select(pins[1:0]), .chip_reset_n(chip_reset_n),
        .line_gain_range_select(pins[2]), .rx_powerdown_pin(pins[3]),
        .tx_test_sequence_select(pins[5:4]),
        .jitter_filter_select(pins[7:6]), .tx_driver_float(pins[8]),
        .line_template_select(pins[12:9]), .mux_bus_in(bus_in),
        .mux_bus_out(bus_out), .mux_bus_oe(bus_oe),
        .core_reset(core_reset), .eq_long_haul(dec[10]),
        .rx_powerdown(dec[9]), .tx_powerdown(dec[8]),
        .tx_pattern(dec[7:6]), .ja_mode(dec[5:4]),
        .ja_in_tx_path(dec[3]), .ja_fifo_deep(dec[2]),
        .ja_narrow_bw(dec[1]), .tx_driver_oe(dec[0]));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [10:0] exp_dec(input logic [12:0] p);
        logic hw;
        hw = (p[1:0] == 2'b00);
        return {hw & p[2], hw & p[3], hw & (p[5:4] == 2'b11),
                (hw && p[5:4] != 2'b11) ? p[5:4] : 2'b00,
                hw ? p[7:6] : 2'b00, hw & (p[7:6] == 2'b11),
                hw & p[7], hw & p[7], ~p[8]};
    endfunction
    function automatic logic [15:0] exp_stat(input logic [12:0] p);
        return {p[12:9], 2'b00, p[1:0], 1'b0, p[8:2]};
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
        oe_seen = bus_oe;
        @(posedge pclk);
    endtask

    task automatic apply(input logic [12:0] v);
        logic [12:0] p;
        want <= v;
        p = (v[1:0] == 2'b00) ? v : {v[12:8], 2'b00, v[5:0]};
        repeat (6) @(posedge pclk);
        chk("decoded", {5'h00, exp_dec(p)}, {5'h00, dec});
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("status", exp_stat(p), rd[15:0] & 16'hf77f);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        end_of_test;
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 16; i++) begin
            apply({4'h5, i[3], i[3:2], i[1:0], i[2], i[0] ^ i[1], 2'b00});
        end
        for (int m = 0; m < 4; m++) begin
            apply(13'($random(seed)) & 13'h1ffc | 13'(m));
            apb(1'b0, 12'h008, 32'h0000_0000);
            chk("bus enable", {15'h0000, m[1]}, {15'h0000, oe_seen});
        end
        for (int i = 0; i < 20; i++) begin
            apply(13'($random(seed)));
        end
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk("slave error", 16'h0001, {15'h0000, er});
        apb(1'b1, 12'h004, 32'h0000_0001);
        repeat (4) @(posedge pclk);
        chk("soft reset", 16'h0001, {15'h0000, core_reset});
        apb(1'b1, 12'h004, 32'h0000_0000);
        chip_reset_n <= 1'b0;
        repeat (3) @(posedge pclk);
        chip_reset_n <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("short pulse", 16'h0000, {15'h0000, core_reset});
        chip_reset_n <= 1'b0;
        repeat (12) @(posedge pclk);
        chk("chip reset", 16'h0001, {15'h0000, core_reset});
        chip_reset_n <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("reset release", 16'h0000, {15'h0000, core_reset});
        end_of_test;
    end
endmodule // liuhw_top_tb
`default_nettype wire
